// ### cer_reporter.sv
`timescale 1ns/10ps
module cer_reporter #(
  parameter int MOD_SLOTS = 32
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  // own node address
  input  wire logic [6:0]  node_addr_i,
  // module alarm events
  input  wire logic        mod_valid_i,
  input  wire logic        mod_incoming_i,
  input  wire logic [7:0]  mod_idx_i,
  input  wire logic [31:0] mod_diag_i,
  output logic             mod_ready_o,
  // can controller faults
  input  wire logic        rx_ovf_i,
  input  wire logic        err_passive_i,
  input  wire logic        bus_off_i,
  input  wire logic        tx_ovf_i,
  input  wire logic        init_fail_i,
  input  wire logic        guard_lost_i,
  // emergency frame toward can transmitter
  output logic             emcy_valid_o,
  input  wire logic        emcy_ready_i,
  output logic [10:0]      emcy_id_o,
  output logic [3:0]       emcy_dlc_o,
  output logic [63:0]      emcy_data_o,
  // internal module bus error report
  output logic             ibus_err_valid_o,
  output logic [15:0]      ibus_err_code_o,
  // error history entry
  output logic             hist_valid_o,
  output logic [31:0]      hist_data_o,
  // emergency state
  output logic             err_present_o
);

  localparam int IW = (MOD_SLOTS > 1) ? $clog2(MOD_SLOTS) : 1;

  // ==========================================================
  // parameter check
  if (MOD_SLOTS < 2 || MOD_SLOTS > 256 ||
      (MOD_SLOTS & (MOD_SLOTS - 1)) != 0) begin : g_bad_slots
    $error("MOD_SLOTS must be a power of two from 2 to 256");
  end

  // ==========================================================
  // state
  typedef struct packed {
    cer_pkg::cer_emcy_state_t state;
    logic [MOD_SLOTS-1:0]     pend;
    logic                     mod_ready;
    logic                     emcy_valid;
    logic [10:0]              emcy_id;
    logic [63:0]              emcy_data;
    logic                     ibus_valid;
    logic [15:0]              ibus_code;
    logic                     hist_valid;
    logic [31:0]              hist_data;
  } cer_rep_state_t;

  cer_rep_state_t s_r;
  cer_rep_state_t s_nxt;

  // ==========================================================
  // fault flags
  logic [cer_pkg::CER_FLT_NUM-1:0] flt_in;
  logic [cer_pkg::CER_FLT_NUM-1:0] flt_pend;
  logic [cer_pkg::CER_FLT_NUM-1:0] flt_grant;

  assign flt_in[cer_pkg::CER_FLT_INIT]    = init_fail_i;
  assign flt_in[cer_pkg::CER_FLT_BUS_OFF] = bus_off_i;
  assign flt_in[cer_pkg::CER_FLT_GUARD]   = guard_lost_i;
  assign flt_in[cer_pkg::CER_FLT_PASSIVE] = err_passive_i;
  assign flt_in[cer_pkg::CER_FLT_TX_OVF]  = tx_ovf_i;
  assign flt_in[cer_pkg::CER_FLT_RX_OVF]  = rx_ovf_i;

  for (genvar g = 0; g < cer_pkg::CER_FLT_NUM; g++) begin : g_flt
    cer_event_flag u_flag (
      .clk_i     (clk_i),
      .reset_n_i (reset_n_i),
      .set_i     (flt_in[g]),
      .clr_i     (flt_grant[g]),
      .flag_o    (flt_pend[g])
    );
  end

  // ==========================================================
  // event handling
  logic                 slot_free;
  logic                 take_mod;
  logic                 idx_ok;
  logic [IW-1:0]        idx;
  logic [MOD_SLOTS-1:0] pend_after;
  logic [10:0]          frame_id;
  int                   sel;

  assign idx_ok    = ({1'b0, mod_idx_i} < 9'(MOD_SLOTS));
  assign idx       = mod_idx_i[IW-1:0];
  assign slot_free = !s_r.emcy_valid || emcy_ready_i;
  assign take_mod  = mod_valid_i && s_r.mod_ready;
  assign frame_id  = cer_pkg::CER_EMCY_ID_BASE + {4'h0, node_addr_i};

  always_comb begin
    s_nxt            = s_r;
    s_nxt.ibus_valid = 1'b0;
    s_nxt.hist_valid = 1'b0;
    flt_grant        = '0;
    pend_after       = s_r.pend;
    sel              = 0;
    if (s_r.emcy_valid && emcy_ready_i) begin
      s_nxt.emcy_valid = 1'b0;
    end
    if (take_mod) begin
      if (idx_ok && mod_incoming_i) begin
        pend_after[idx] = 1'b1;
        s_nxt.pend      = pend_after;
        s_nxt.state     = cer_pkg::CER_ERR_PRESENT;
        s_nxt.emcy_valid = 1'b1;
        s_nxt.emcy_id   = frame_id;
        if (s_r.state == cer_pkg::CER_ERR_FREE) begin
          s_nxt.emcy_data = cer_pkg::cer_frame(cer_pkg::CER_EC_FIRST,
            cer_pkg::CER_REG_MODULE, mod_idx_i, mod_diag_i);
        end else begin
          s_nxt.emcy_data = cer_pkg::cer_frame(cer_pkg::CER_EC_FURTHER,
            cer_pkg::CER_REG_MODULE, mod_idx_i, mod_diag_i);
        end
        s_nxt.hist_valid = 1'b1;
        s_nxt.hist_data  = mod_diag_i;
      end else if (idx_ok && s_r.pend[idx]) begin
        pend_after[idx]  = 1'b0;
        s_nxt.pend       = pend_after;
        s_nxt.emcy_valid = 1'b1;
        s_nxt.emcy_id    = frame_id;
        if (|pend_after) begin
          s_nxt.emcy_data = cer_pkg::cer_frame(cer_pkg::CER_EC_PARTIAL,
            cer_pkg::CER_REG_MODULE, mod_idx_i, mod_diag_i);
          s_nxt.hist_valid = 1'b1;
          s_nxt.hist_data  = mod_diag_i;
        end else begin
          s_nxt.state     = cer_pkg::CER_ERR_FREE;
          s_nxt.emcy_data = cer_pkg::cer_frame(cer_pkg::CER_EC_CLEAR,
            cer_pkg::CER_REG_NONE, 8'h00, 32'h0000_0000);
        end
      end
    end else if (slot_free && (|flt_pend)) begin
      for (int i = cer_pkg::CER_FLT_NUM - 1; i >= 0; i--) begin
        if (flt_pend[i]) begin
          sel = i;
        end
      end
      flt_grant[sel]   = 1'b1;
      s_nxt.ibus_valid = 1'b1;
      s_nxt.ibus_code  = cer_pkg::CER_IBUS_CODE[sel];
      if (cer_pkg::CER_FLT_SENDS[sel]) begin
        s_nxt.emcy_valid = 1'b1;
        s_nxt.emcy_id    = frame_id;
        s_nxt.emcy_data  = cer_pkg::cer_frame(cer_pkg::CER_FLT_EMCY[sel],
          cer_pkg::CER_REG_COMM, cer_pkg::CER_FLT_BYTE1[sel], 32'h0000_0000);
      end
    end
    // faults go first; a module event waits for an empty slot
    s_nxt.mod_ready = !s_nxt.emcy_valid &&
                      ((flt_pend & ~flt_grant) == '0) && (flt_in == '0);
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign mod_ready_o      = s_r.mod_ready;
  assign emcy_valid_o     = s_r.emcy_valid;
  assign emcy_id_o        = s_r.emcy_id;
  assign emcy_dlc_o       = cer_pkg::CER_EMCY_DLC;
  assign emcy_data_o      = s_r.emcy_data;
  assign ibus_err_valid_o = s_r.ibus_valid;
  assign ibus_err_code_o  = s_r.ibus_code;
  assign hist_valid_o     = s_r.hist_valid;
  assign hist_data_o      = s_r.hist_data;
  assign err_present_o    = (s_r.state == cer_pkg::CER_ERR_PRESENT);

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  logic take_in;
  logic take_out;
  assign take_in  = take_mod && idx_ok && mod_incoming_i;
  assign take_out = take_mod && idx_ok && !mod_incoming_i && s_r.pend[idx];

  sequence s_first_in;
    take_in && !err_present_o;
  endsequence

  sequence s_frame_out(logic [15:0] c, logic [7:0] r);
    emcy_valid_o && emcy_data_o[15:0] == c && emcy_data_o[23:16] == r;
  endsequence

  a_first_error: assert property (s_first_in |=>
    s_frame_out(cer_pkg::CER_EC_FIRST, cer_pkg::CER_REG_MODULE) and
    (err_present_o && emcy_data_o[31:24] == $past(mod_idx_i)))
    else $error("first error frame wrong");

  a_further_error: assert property (take_in && err_present_o |=>
    s_frame_out(cer_pkg::CER_EC_FURTHER, cer_pkg::CER_REG_MODULE))
    else $error("further error frame wrong");

  a_partial_clear: assert property (take_out && (|pend_after) |=>
    s_frame_out(cer_pkg::CER_EC_PARTIAL, cer_pkg::CER_REG_MODULE) and
    (err_present_o && hist_valid_o))
    else $error("partial clear frame wrong");

  a_all_clear: assert property (take_out && pend_after == '0 |=>
    emcy_valid_o && emcy_data_o == '0 && !err_present_o && !hist_valid_o)
    else $error("all clear frame wrong");

  a_hist_diag: assert property (take_in |=>
    hist_valid_o && hist_data_o == $past(mod_diag_i) ##1 !hist_valid_o)
    else $error("history entry wrong");

  a_state_pend: assert property (err_present_o == (|s_r.pend))
    else $error("state disagrees with pending set");

  a_rx_ovf_map: assert property (
    flt_grant[cer_pkg::CER_FLT_RX_OVF] |=>
    ibus_err_valid_o && ibus_err_code_o == 16'h4501 &&
    emcy_data_o[15:0] == 16'h8110 && emcy_data_o[31:24] == 8'h01)
    else $error("rx overflow report wrong");

  a_bus_off_quiet: assert property (
    flt_grant[cer_pkg::CER_FLT_BUS_OFF] |=>
    ibus_err_valid_o && ibus_err_code_o == 16'h4504 && !emcy_valid_o)
    else $error("bus off sent a frame");

  a_frame_ident: assert property ($rose(emcy_valid_o) |->
    emcy_id_o == cer_pkg::CER_EMCY_ID_BASE + {4'h0, $past(node_addr_i)}
    && emcy_dlc_o == cer_pkg::CER_EMCY_DLC)
    else $error("frame identifier wrong");

  a_frame_hold: assert property (emcy_valid_o && !emcy_ready_i |=>
    emcy_valid_o && $stable(emcy_data_o) && $stable(emcy_id_o))
    else $error("frame changed before taken");

  a_ready_gate: assert property (emcy_valid_o |-> !mod_ready_o)
    else $error("module request open while frame waits");

  a_idx_ignored: assert property (take_mod && !idx_ok |=>
    !emcy_valid_o && !hist_valid_o)
    else $error("out of range index was acted on");

  // ==========================================================
  // fault mapping checks
  logic any_grant;
  assign any_grant = |flt_grant;

  sequence s_ibus_out(logic [15:0] c);
    ibus_err_valid_o && ibus_err_code_o == c;
  endsequence

  sequence s_comm_frame(logic [15:0] c, logic [7:0] b1);
    emcy_valid_o && emcy_data_o[15:0] == c &&
    emcy_data_o[23:16] == cer_pkg::CER_REG_COMM &&
    emcy_data_o[31:24] == b1 && emcy_data_o[63:32] == '0;
  endsequence

  a_grant_single: assert property ($onehot0(flt_grant))
    else $error("more than one fault served at once");

  a_fault_report: assert property (
    ibus_err_valid_o == $past(any_grant))
    else $error("internal bus report without a served fault");

  a_passive_map: assert property (
    flt_grant[cer_pkg::CER_FLT_PASSIVE] |=>
    s_ibus_out(16'h4503) and s_comm_frame(16'h8120, 8'h00))
    else $error("error passive report wrong");

  a_tx_ovf_map: assert property (
    flt_grant[cer_pkg::CER_FLT_TX_OVF] |=>
    s_ibus_out(16'h4506) and s_comm_frame(16'h8110, 8'h02))
    else $error("tx overflow report wrong");

  a_guard_map: assert property (
    flt_grant[cer_pkg::CER_FLT_GUARD] |=>
    s_ibus_out(16'h4508) and s_comm_frame(16'h8130, 8'h00))
    else $error("guard loss report wrong");

  a_init_quiet: assert property (
    flt_grant[cer_pkg::CER_FLT_INIT] |=>
    s_ibus_out(16'hc507) ##0 !emcy_valid_o)
    else $error("init failure sent a frame");

endmodule

// ### cer_pkg.sv
package cer_pkg;

  // ==========================================================
  // emergency states
  typedef enum logic {
    CER_ERR_FREE,
    CER_ERR_PRESENT
  } cer_emcy_state_t;

  // ==========================================================
  // frame layout
  localparam logic [10:0] CER_EMCY_ID_BASE = 11'h080;
  localparam logic [3:0]  CER_EMCY_DLC     = 4'h8;

  // ==========================================================
  // module alarm codes
  localparam logic [15:0] CER_EC_FIRST   = 16'hff01;
  localparam logic [15:0] CER_EC_PARTIAL = 16'hff02;
  localparam logic [15:0] CER_EC_FURTHER = 16'hff03;
  localparam logic [15:0] CER_EC_CLEAR   = 16'h0000;
  localparam logic [7:0]  CER_REG_MODULE = 8'h81;
  localparam logic [7:0]  CER_REG_NONE   = 8'h00;
  localparam logic [7:0]  CER_REG_COMM   = 8'h11;

  // ==========================================================
  // can fault table, index is priority (0 highest)
  localparam int CER_FLT_NUM     = 6;
  localparam int CER_FLT_INIT    = 0;
  localparam int CER_FLT_BUS_OFF = 1;
  localparam int CER_FLT_GUARD   = 2;
  localparam int CER_FLT_PASSIVE = 3;
  localparam int CER_FLT_TX_OVF  = 4;
  localparam int CER_FLT_RX_OVF  = 5;

  localparam logic [15:0] CER_IBUS_CODE [CER_FLT_NUM] = '{
    16'hc507, 16'h4504, 16'h4508, 16'h4503, 16'h4506, 16'h4501};
  localparam logic [15:0] CER_FLT_EMCY [CER_FLT_NUM] = '{
    16'h0000, 16'h0000, 16'h8130, 16'h8120, 16'h8110, 16'h8110};
  localparam logic CER_FLT_SENDS [CER_FLT_NUM] = '{
    1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
  localparam logic [7:0] CER_FLT_BYTE1 [CER_FLT_NUM] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h01};

  // byte order on the wire: code lo, code hi, register, index, diag
  function automatic logic [63:0] cer_frame(input logic [15:0] code,
                                            input logic [7:0]  regv,
                                            input logic [7:0]  idx,
                                            input logic [31:0] diag);
    cer_frame = {diag, idx, regv, code[15:8], code[7:0]};
  endfunction

endpackage

// ### cer_event_flag.sv
`timescale 1ns/10ps
module cer_event_flag (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  // event in, service clear
  input  wire logic set_i,
  input  wire logic clr_i,
  // pending flag
  output logic      flag_o
);

  typedef struct packed {
    logic flag;
  } cer_flag_state_t;

  cer_flag_state_t s_r;
  cer_flag_state_t s_nxt;

  // set wins over a clear in the same cycle
  always_comb begin
    s_nxt      = s_r;
    s_nxt.flag = set_i | (s_r.flag & ~clr_i);
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign flag_o = s_r.flag;

endmodule

// ### cer_consumer.sv
`timescale 1ns/10ps
// ==========================================================
// emergency consumer: acks each frame after stall_i cycles
module cer_consumer (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  // frame from the reporter
  input  wire logic        valid_i,
  input  wire logic [10:0] id_i,
  input  wire logic [3:0]  dlc_i,
  input  wire logic [63:0] data_i,
  input  wire logic [3:0]  stall_i,
  output logic             ready_o,
  // last frame taken
  output logic [10:0]      id_o,
  output logic [3:0]       dlc_o,
  output logic [63:0]      data_o,
  output int               count_o
);
  logic [3:0] wait_r;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ready_o <= 1'b0;
      wait_r  <= 4'h0;
      count_o <= 0;
      id_o    <= 11'h000;
      dlc_o   <= 4'h0;
      data_o  <= 64'h0;
    end else if (ready_o && valid_i) begin
      ready_o <= 1'b0;
      wait_r  <= 4'h0;
      count_o <= count_o + 1;
      id_o    <= id_i;
      dlc_o   <= dlc_i;
      data_o  <= data_i;
    end else if (valid_i) begin
      if (wait_r >= stall_i) begin
        ready_o <= 1'b1;
      end else begin
        wait_r <= wait_r + 4'h1;
      end
    end
  end
endmodule

// ### canopen_emergency_reporter_tb.sv
`timescale 1ns/10ps
module canopen_emergency_reporter_tb;
  logic        clk_i;
  logic        reset_n_i;
  logic        mod_valid_i;
  logic        mod_incoming_i;
  logic [7:0]  mod_idx_i;
  logic [31:0] mod_diag_i;
  logic [5:0]  flt;
  logic [3:0]  stall;
  logic [6:0]  node_addr;
  logic        mod_ready_o;
  logic        emcy_valid_o;
  logic        emcy_ready_i;
  logic [10:0] emcy_id_o;
  logic [3:0]  emcy_dlc_o;
  logic [63:0] emcy_data_o;
  logic        ibus_err_valid_o;
  logic [15:0] ibus_err_code_o;
  logic        hist_valid_o;
  logic [31:0] hist_data_o;
  logic        err_present_o;
  logic [10:0] f_id;
  logic [3:0]  f_dlc;
  logic [63:0] f_data;
  int          f_cnt;
  int          fails;
  int          n_tests;
  int          n_hist;
  int          n_ibus;
  logic [31:0] hist_q;
  logic [15:0] ibus_q;
  // fault order: init, bus-off, guard, passive, tx, rx
  logic [15:0] ib_code [6] = '{16'hc507, 16'h4504, 16'h4508,
                               16'h4503, 16'h4506, 16'h4501};
  logic [15:0] em_code [6] = '{16'h0000, 16'h0000, 16'h8130,
                               16'h8120, 16'h8110, 16'h8110};
  logic [7:0]  em_b1 [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h01};

  cer_reporter cer_reporter_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .node_addr_i(node_addr), .mod_valid_i(mod_valid_i),
    .mod_incoming_i(mod_incoming_i), .mod_idx_i(mod_idx_i),
    .mod_diag_i(mod_diag_i), .mod_ready_o(mod_ready_o),
    .rx_ovf_i(flt[5]), .err_passive_i(flt[3]), .bus_off_i(flt[1]),
    .tx_ovf_i(flt[4]), .init_fail_i(flt[0]), .guard_lost_i(flt[2]),
    .emcy_valid_o(emcy_valid_o), .emcy_ready_i(emcy_ready_i),
    .emcy_id_o(emcy_id_o), .emcy_dlc_o(emcy_dlc_o),
    .emcy_data_o(emcy_data_o), .ibus_err_valid_o(ibus_err_valid_o),
    .ibus_err_code_o(ibus_err_code_o), .hist_valid_o(hist_valid_o),
    .hist_data_o(hist_data_o), .err_present_o(err_present_o));

  cer_consumer cer_consumer_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .valid_i(emcy_valid_o), .id_i(emcy_id_o), .dlc_i(emcy_dlc_o),
    .data_i(emcy_data_o), .stall_i(stall), .ready_o(emcy_ready_i),
    .id_o(f_id), .dlc_o(f_dlc), .data_o(f_data), .count_o(f_cnt));

  // ==========================================================
  // clock, pulse monitors, watchdog
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (hist_valid_o === 1'b1) begin
      n_hist++;
      hist_q = hist_data_o;
    end
    if (ibus_err_valid_o === 1'b1) begin
      n_ibus++;
      ibus_q = ibus_err_code_o;
    end
  end
  initial begin
    #2000000;
    fails++;
    conclude();
  end

  // ==========================================================
  // shared tasks
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (mod_ready_o !== 1'b1 && n < 60);
    chk(n < 60, 1'b1);
  endtask

  task automatic mod_evt(input logic inc, input logic [7:0] idx,
                         input logic [31:0] dg, input logic [15:0] code,
                         input logic [7:0] rg, input bit fr,
                         input bit hs, input bit pres);
    int f0;
    int h0;
    f0 = f_cnt;
    h0 = n_hist;
    @(posedge clk_i);
    mod_valid_i    <= 1'b1;
    mod_incoming_i <= inc;
    mod_idx_i      <= idx;
    mod_diag_i     <= dg;
    wait_ready();
    mod_valid_i <= 1'b0;
    wait_ready();
    chk(f_cnt - f0, fr);
    if (fr) chk(f_data, {pres ? {dg, idx} : 40'h0, rg, code});
    if (fr) chk({f_id, f_dlc}, {11'h080 + {4'h0, node_addr}, 4'h8});
    chk(n_hist - h0, hs);
    if (hs) chk(hist_q, dg);
    chk(err_present_o, pres);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_first();
    stall <= 4'h0;
    mod_evt(1, 8'h03, 32'h0000_0040, 16'hff01, 8'h81, 1, 1, 1);
  endtask

  task automatic t_further();
    stall <= 4'h3;
    mod_evt(1, 8'h0e, 32'h0001_0000, 16'hff03, 8'h81, 1, 1, 1);
  endtask

  task automatic t_partial();
    node_addr <= 7'h25;
    mod_evt(0, 8'h03, 32'h1234_5678, 16'hff02, 8'h81, 1, 1, 1);
  endtask

  task automatic t_clear();
    stall <= 4'h1;
    mod_evt(0, 8'h0e, 32'hdead_beef, 16'h0000, 8'h00, 1, 0, 0);
    chk(f_cnt, 4);
    chk(f_data, 64'h0);
    mod_evt(0, 8'h09, 32'h0000_0001, 16'h0000, 8'h00, 0, 0, 0);
    mod_evt(1, 8'h40, 32'h0000_0002, 16'h0000, 8'h00, 0, 0, 0);
  endtask

  task automatic t_faults();
    int f0;
    int h0;
    int i0;
    int n;
    for (int k = 0; k < 6; k++) begin
      f0 = f_cnt;
      h0 = n_hist;
      i0 = n_ibus;
      @(posedge clk_i);
      flt[k] <= 1'b1;
      @(posedge clk_i);
      flt <= 6'h00;
      n = 0;
      while (n_ibus == i0 && n < 50) begin
        @(posedge clk_i);
        n++;
      end
      wait_ready();
      chk(n_ibus - i0, 1);
      chk(ibus_q, ib_code[k]);
      chk(f_cnt - f0, em_code[k] != 16'h0);
      if (em_code[k] != 16'h0)
        chk(f_data, {32'h0, em_b1[k], 8'h11, em_code[k]});
      chk(n_hist - h0, 0);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    reset_n_i      = 1'b0;
    mod_valid_i    = 1'b0;
    mod_incoming_i = 1'b0;
    mod_idx_i      = 8'h00;
    mod_diag_i     = 32'h0;
    flt            = 6'h00;
    stall          = 4'h0;
    node_addr      = 7'h0c;
    repeat (4) @(posedge clk_i);
    reset_n_i <= 1'b1;
    wait_ready();
    chk(err_present_o, 1'b0);
    t_first();
    t_further();
    t_partial();
    t_clear();
    t_faults();
    conclude();
  end
endmodule
